// file: hw/ctxe_encoder.v
// Purpose: transmit encoder with its setup registers on a classic wishbone slave
// Assumes: symbols arrive from logic on core_clk_in, one byte per handshake
// Notes: mod_out_out is high while the carrier is to be modulated
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ctxe_consts.vh"
module ctxe_encoder (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // wishbone slave
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [7:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output wire [31:0] wb_dat_out,
   output wire wb_ack_out,
   // symbol stream
   input wire sym_valid_in,
   input wire [7:0] sym_in,
   output wire sym_ready_out,
   // modulator
   output wire mod_out_out
);
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // oscillator periods per encoder clock, zero for reserved codes
   function [9:0] rate_div;
      input [2:0] code;
      begin
         case (code)
            `CTXE_RATE_106K: rate_div = 10'd128;
            `CTXE_RATE_53K: rate_div = 10'd256;
            `CTXE_RATE_26K: rate_div = 10'd512;
            default: rate_div = 10'd0;
         endcase
      end
   endfunction

   // coding code is one of the defined ones
   function code_ok;
      input [2:0] code;
      begin
         code_ok = code[2];
      end
   endfunction

   reg [7:0] setup_reg;
   reg [7:0] width_reg;
   reg [1:0] msel_reg;
   reg ack_reg;
   reg [31:0] rdata_reg;
   reg [16:0] acc_reg;
   reg osc_tick_reg;
   reg [9:0] div_reg;
   reg state_reg;
   reg [7:0] byte_reg;
   reg [2:0] sym_idx_reg;
   reg [7:0] slot_reg;
   reg ready_reg;
   reg force_prev_reg;
   reg fire_reg;
   reg mod_reg;
   wire pulse_active;
   wire [2:0] rate_sel;
   wire [2:0] tx_code_sel;
   wire [9:0] div_max;
   wire cfg_ok;
   wire enc_tick;
   wire wr_stb;
   wire [5:0] idx;
   reg [7:0] sym_val;
   reg [7:0] slot_last;
   reg [2:0] sym_last;
   reg slot_pulse;
   reg state_next;
   reg [31:0] rdata_next;

   assign wb_ack_out = ack_reg;
   assign wb_dat_out = rdata_reg;
   assign sym_ready_out = ready_reg;
   assign mod_out_out = mod_reg;
   assign rate_sel = setup_reg[`CTXE_RATE_HI:`CTXE_RATE_LO];
   assign tx_code_sel = setup_reg[`CTXE_CODE_HI:`CTXE_CODE_LO];
   assign div_max = rate_div(rate_sel);
   assign cfg_ok = (div_max != 10'd0) && code_ok(tx_code_sel);
   assign idx = wb_adr_in[7:2];
   assign wr_stb = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg && wb_sel_in[0];
   assign enc_tick = osc_tick_reg && (div_reg == div_max - 10'd1);

   // bus slave: ack one cycle after the strobe, write lands with ack
   always @* begin
      rdata_next = 32'h00000000;
      case (idx)
         `CTXE_IDX_TX_SOURCE: rdata_next[`CTXE_MSEL_HI:`CTXE_MSEL_LO] = msel_reg;
         `CTXE_IDX_ENC_SETUP: rdata_next[7:0] = setup_reg;
         `CTXE_IDX_PULSE_WIDTH: rdata_next[7:0] = width_reg;
         `CTXE_IDX_STATUS: rdata_next[3:0] = {cfg_ok, ready_reg, pulse_active, state_reg};
         default: rdata_next = 32'h00000000;
      endcase
   end

   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         setup_reg <= `CTXE_RST_ENC_SETUP;
         width_reg <= `CTXE_RST_PULSE_WIDTH;
         msel_reg <= `CTXE_RST_MOD_SEL;
      end else begin
         ack_reg <= wb_cyc_in && wb_stb_in && !ack_reg;
         rdata_reg <= rdata_next;
         if (wr_stb) begin
            case (idx)
               // force bit is stored as written and only software clears it
               `CTXE_IDX_ENC_SETUP: setup_reg <= wb_dat_in[7:0];
               `CTXE_IDX_PULSE_WIDTH: width_reg <= wb_dat_in[7:0];
               `CTXE_IDX_TX_SOURCE: msel_reg <= wb_dat_in[`CTXE_MSEL_HI:`CTXE_MSEL_LO];
               default: msel_reg <= msel_reg;
            endcase
         end
      end
   end

   // oscillator tick and encoder clock divider
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_reg <= 17'd0;
         osc_tick_reg <= 1'b0;
         div_reg <= 10'd0;
      end else begin
         if (acc_reg + `CTXE_OSC_KHZ >= `CTXE_CORE_KHZ) begin
            acc_reg <= acc_reg + `CTXE_OSC_KHZ - `CTXE_CORE_KHZ;
            osc_tick_reg <= 1'b1;
         end else begin
            acc_reg <= acc_reg + `CTXE_OSC_KHZ;
            osc_tick_reg <= 1'b0;
         end
         if (state_reg == ST_IDLE || !cfg_ok) begin
            div_reg <= 10'd0;
         end else if (osc_tick_reg) begin
            div_reg <= enc_tick ? 10'd0 : div_reg + 10'd1;
         end
      end
   end

   // symbol layout per coding mode
   always @* begin
      sym_val = byte_reg;
      slot_last = 8'hff;
      sym_last = 3'd0;
      case (tx_code_sel)
         `CTXE_CODE_STD256, `CTXE_CODE_ISO256: begin
            sym_val = byte_reg;
            slot_last = 8'hff;
            sym_last = 3'd0;
         end
         `CTXE_CODE_FAST_RZ: begin
            sym_val = {7'h00, byte_reg[sym_idx_reg]};
            slot_last = 8'h00;
            sym_last = 3'd7;
         end
         `CTXE_CODE_ISO4: begin
            sym_val = {6'h00, byte_reg[{sym_idx_reg[1:0], 1'b1}], byte_reg[{sym_idx_reg[1:0], 1'b0}]};
            slot_last = 8'h03;
            sym_last = 3'd3;
         end
         default: begin
            sym_val = 8'h00;
            slot_last = 8'h00;
            sym_last = 3'd0;
         end
      endcase
      if (tx_code_sel == `CTXE_CODE_FAST_RZ) begin
         slot_pulse = sym_val[0];
      end else begin
         slot_pulse = (slot_reg == sym_val);
      end
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (sym_valid_in && ready_reg) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (enc_tick && slot_reg == slot_last && sym_idx_reg == sym_last) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // encoder sequencing
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= ST_IDLE;
         byte_reg <= 8'h00;
         sym_idx_reg <= 3'd0;
         slot_reg <= 8'h00;
         ready_reg <= 1'b0;
         force_prev_reg <= 1'b0;
         fire_reg <= 1'b0;
         mod_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ready_reg <= (state_next == ST_IDLE) && cfg_ok && !(sym_valid_in && ready_reg);
         force_prev_reg <= setup_reg[`CTXE_FORCE_BIT];
         fire_reg <= (setup_reg[`CTXE_FORCE_BIT] && !force_prev_reg) ||
                     (state_reg == ST_RUN && enc_tick && slot_pulse);
         if (state_reg == ST_IDLE) begin
            if (sym_valid_in && ready_reg) begin
               byte_reg <= sym_in;
            end
            sym_idx_reg <= 3'd0;
            slot_reg <= 8'h00;
         end else if (enc_tick) begin
            if (slot_reg == slot_last) begin
               slot_reg <= 8'h00;
               sym_idx_reg <= sym_idx_reg + 3'd1;
            end else begin
               slot_reg <= slot_reg + 8'h01;
            end
         end
         case (msel_reg)
            `CTXE_MSEL_LOW: mod_reg <= 1'b0;
            `CTXE_MSEL_HIGH: mod_reg <= 1'b1;
            `CTXE_MSEL_ENC: mod_reg <= pulse_active;
            default: mod_reg <= 1'b0;
         endcase
      end
   end

   ctxe_pulse_gen u_pulse (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .osc_tick_in(osc_tick_reg),
      .start_in(fire_reg),
      .width_in(width_reg),
      .active_out(pulse_active)
   );
endmodule // ctxe_encoder

// file: hw/ctxe_consts.vh
// Purpose: constants of the contactless transmit encoder configuration block
// Assumes: register index times four is the byte address on the bus
// Notes: definitions only
`ifndef CTXE_CONSTS_VH
`define CTXE_CONSTS_VH

// register indices
`define CTXE_IDX_TX_SOURCE 6'h11
`define CTXE_IDX_ENC_SETUP 6'h14
`define CTXE_IDX_PULSE_WIDTH 6'h15
`define CTXE_IDX_STATUS 6'h1f

// reset values
`define CTXE_RST_ENC_SETUP 8'h2c
`define CTXE_RST_PULSE_WIDTH 8'h3f
`define CTXE_RST_MOD_SEL 2'h2

// encoder setup fields
`define CTXE_FORCE_BIT 7
`define CTXE_KEEP_BIT 6
`define CTXE_RATE_HI 5
`define CTXE_RATE_LO 3
`define CTXE_CODE_HI 2
`define CTXE_CODE_LO 0
// tx source field
`define CTXE_MSEL_HI 6
`define CTXE_MSEL_LO 5

// clock rate codes
`define CTXE_RATE_106K 3'h4
`define CTXE_RATE_53K 3'h5
`define CTXE_RATE_26K 3'h6
// coding codes
`define CTXE_CODE_STD256 3'h4
`define CTXE_CODE_FAST_RZ 3'h5
`define CTXE_CODE_ISO256 3'h6
`define CTXE_CODE_ISO4 3'h7
// modulator source codes
`define CTXE_MSEL_LOW 2'h0
`define CTXE_MSEL_HIGH 2'h1
`define CTXE_MSEL_ENC 2'h2

// oscillator tick synthesis: 13.56 MHz from the 100 MHz core clock
`define CTXE_OSC_KHZ 17'd13560
`define CTXE_CORE_KHZ 17'd100000

`endif

// file: hw/ctxe_pulse_gen.v
// Purpose: one modulation pulse of programmable width
// Assumes: osc_tick_in pulses once per oscillator period
// Notes: width is 2 x (n + 1) oscillator periods
`timescale 1ns/1ps
module ctxe_pulse_gen (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // control
   input wire osc_tick_in,
   input wire start_in,
   input wire [7:0] width_in,
   // pulse
   output wire active_out
);
   reg active_reg;
   reg pend_reg;
   reg [8:0] cnt_reg;

   assign active_out = active_reg;

   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         active_reg <= 1'b0;
         pend_reg <= 1'b0;
         cnt_reg <= 9'h000;
      end else if (!active_reg) begin
         // begin on an oscillator tick so the pulse spans whole periods
         if (osc_tick_in && (start_in || pend_reg)) begin
            active_reg <= 1'b1;
            pend_reg <= 1'b0;
            cnt_reg <= {width_in, 1'b1};
         end else if (start_in) begin
            pend_reg <= 1'b1;
         end
      end else if (osc_tick_in) begin
         if (cnt_reg == 9'h000) begin
            active_reg <= 1'b0;
         end
         cnt_reg <= cnt_reg - 9'h001;
      end
   end
endmodule // ctxe_pulse_gen

// file: verification/ctxe_encoder_properties.sv
// Purpose: port assertions for ctxe_encoder
// Assumes: bound into every ctxe_encoder
// Notes: shadows follow bus writes
`timescale 1ns/1ps
module ctxe_encoder_properties (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // bus
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [7:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   input wire [31:0] wb_dat_out,
   input wire wb_ack_out,
   // stream and modulator
   input wire sym_valid_in,
   input wire sym_ready_out,
   input wire mod_out_out
);
   reg [7:0] setup_reg;
   reg [7:0] width_reg;
   reg [1:0] msel_reg;
   reg [15:0] high_reg;
   wire req = wb_cyc_in && wb_stb_in;
   wire wr = req && wb_ack_out && wb_we_in && wb_sel_in[0];
   wire rd = req && wb_ack_out && !wb_we_in;
   wire [5:0] idx = wb_adr_in[7:2];
   wire cfg_ok = setup_reg[5] && setup_reg[4:3] != 2'h3 && setup_reg[2];
   wire msel_low = msel_reg == 2'h0;
   wire enc = msel_reg == 2'h2;
   wire [15:0] lim = ({8'h0, width_reg} + 16'h1) * 16'hf + 16'h2;
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         setup_reg <= 8'h2c;
         width_reg <= 8'h3f;
         msel_reg <= 2'h2;
         high_reg <= 16'h0;
      end else begin
         if (wr && idx == 6'h14) setup_reg <= wb_dat_in[7:0];
         if (wr && idx == 6'h15) width_reg <= wb_dat_in[7:0];
         if (wr && idx == 6'h11) msel_reg <= wb_dat_in[6:5];
         high_reg <= mod_out_out ? high_reg + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   a_ack_after_req: assert property (req && !wb_ack_out |=> wb_ack_out) else $error("ack late");
   a_ack_needs_req: assert property (!req |=> !wb_ack_out) else $error("stray ack");
   a_setup_read_back: assert property (rd && idx == 6'h14 |-> wb_dat_out == {24'h0, setup_reg})
      else $error("setup readback");
   a_width_read_back: assert property (rd && idx == 6'h15 |-> wb_dat_out == {24'h0, width_reg})
      else $error("width readback");
   a_ready_drops: assert property (sym_valid_in && sym_ready_out |=> !sym_ready_out)
      else $error("ready held");
   a_ready_cfg_ok: assert property (sym_ready_out |-> $past(cfg_ok)) else $error("reserved accepted");
   a_source_low: assert property ($past(msel_low) && $past(msel_low, 2) |-> !mod_out_out)
      else $error("mod while low");
   a_pulse_min_len: assert property ($rose(mod_out_out) && enc |=> mod_out_out [*8])
      else $error("pulse short");
   a_pulse_max_len: assert property (mod_out_out && enc |-> high_reg < lim) else $error("pulse long");
   c_force: cover property (wr && idx == 6'h14 && wb_dat_in[7]);
   c_take: cover property (sym_valid_in && sym_ready_out);
   c_pulse: cover property ($fell(mod_out_out));
endmodule // ctxe_encoder_properties
bind ctxe_encoder ctxe_encoder_properties u_props (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .sym_valid_in(sym_valid_in), .sym_ready_out(sym_ready_out), .mod_out_out(mod_out_out));

// file: verification/ctxe_label_model.sv
// Purpose: label side listener on the modulator line
// Assumes: mod_in high means carrier modulated
// Notes: times are core clock counts
`timescale 1ns/1ps
module ctxe_label_model (
   // clock
   input wire core_clk_in,
   // carrier
   input wire mod_in
);
   reg prev_reg = 1'b0;
   reg [31:0] now_reg = 32'h0;
   reg [31:0] rise_reg = 32'h0;
   reg [31:0] width_reg = 32'h0;
   reg [31:0] count_reg = 32'h0;
   always @(posedge core_clk_in) begin
      now_reg <= now_reg + 32'h1;
      prev_reg <= mod_in;
      if (mod_in && !prev_reg) rise_reg <= now_reg;
      if (!mod_in && prev_reg) begin
         width_reg <= now_reg - rise_reg;
         count_reg <= count_reg + 32'h1;
      end
   end
endmodule // ctxe_label_model

// file: verification/ctxe_encoder_tb.sv
// Purpose: self-checking bench for ctxe_encoder
// Assumes: 100 MHz core clock
// Notes: slot runs start with a reset
`timescale 1ns/1ps
module ctxe_encoder_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg cyc = 1'b0, stb = 1'b0, we = 1'b0, sv = 1'b0;
   reg [7:0] adr = 8'h0, sym = 8'h0;
   reg [31:0] wdat = 32'h0, q;
   wire [31:0] rdat;
   wire ack, rdy, mod;
   integer error_cnt = 0, checked = 0, t, n, t0;
   always #5 clk = ~clk;
   ctxe_encoder DUT (.core_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .sym_valid_in(sv), .sym_in(sym), .sym_ready_out(rdy), .mod_out_out(mod));
   ctxe_label_model u_label (.core_clk_in(clk), .mod_in(mod));
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task close_out;
      begin
         if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   function [31:0] near(input [31:0] v, input [31:0] e, input [31:0] tol);
      near = (v + tol >= e && v <= e + tol);
   endfunction
   task wb(input w, input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= {24'h0, d};
         @(posedge clk);
         while (ack !== 1'b1) @(posedge clk);
         q = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task pulse_wait(input integer lim);
      begin
         n = u_label.count_reg;
         for (t = 0; t < lim && u_label.count_reg == n; t = t + 1) @(posedge clk);
      end
   endtask
   task t_reset;
      begin
         wb(0, 8'h50, 8'h0);
         chk(q, 32'h2c);
         wb(0, 8'h54, 8'h0);
         chk(q, 32'h3f);
         wb(0, 8'h44, 8'h0);
         chk(q[6:5], 2'h2);
         wb(0, 8'h80, 8'h0);
         chk(q, 32'h0);
      end
   endtask
   task t_force(input [7:0] w, input [31:0] exp);
      begin
         wb(1, 8'h54, w);
         wb(1, 8'h50, 8'hac);
         pulse_wait(1200);
         chk(u_label.count_reg, n + 1);
         chk(near(u_label.width_reg, exp, 3), 1);
         wb(0, 8'h50, 8'h0);
         chk(q, 32'hac);
         wb(1, 8'h50, 8'hac);
         pulse_wait(300);
         chk(u_label.count_reg, n);
         wb(1, 8'h50, 8'h2c);
      end
   endtask
   task t_source;
      begin
         wb(1, 8'h44, 8'h00);
         wb(1, 8'h50, 8'hac);
         pulse_wait(1200);
         chk(u_label.count_reg, n);
         wb(1, 8'h50, 8'h2c);
         wb(1, 8'h44, 8'h20);
         repeat (2) @(posedge clk);
         chk(mod, 1'b1);
         wb(1, 8'h44, 8'h60);
         repeat (2) @(posedge clk);
         chk(mod, 1'b0);
         wb(1, 8'h44, 8'h40);
      end
   endtask
   task t_refuse;
      begin
         wb(1, 8'h50, 8'h20);
         repeat (2) @(posedge clk);
         chk(rdy, 1'b0);
         wb(1, 8'h50, 8'h2c);
         repeat (2) @(posedge clk);
         chk(rdy, 1'b1);
      end
   endtask
   task t_slot(input [2:0] r, input [2:0] c, input [7:0] b, input [31:0] exp);
      begin
         rst_n <= 1'b0;
         repeat (4) @(posedge clk);
         rst_n <= 1'b1;
         wb(1, 8'h54, 8'h03);
         wb(1, 8'h50, {2'h0, r, c});
         @(posedge clk);
         sv <= 1'b1;
         sym <= b;
         @(posedge clk);
         while (rdy !== 1'b1) @(posedge clk);
         t0 = u_label.now_reg;
         sv <= 1'b0;
         pulse_wait(9000);
         chk(near(u_label.rise_reg - t0, exp, 12), 1);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_force(8'h3f, 944);
      t_force(8'h03, 59);
      t_source;
      t_refuse;
      // pulse closes the chosen slot: two encoder periods after the handshake
      t_slot(3'h4, 3'h4, 8'h01, 1888);
      t_slot(3'h4, 3'h6, 8'h01, 1888);
      t_slot(3'h4, 3'h7, 8'h01, 1888);
      t_slot(3'h4, 3'h5, 8'h02, 1888);
      t_slot(3'h5, 3'h5, 8'h02, 3776);
      t_slot(3'h6, 3'h5, 8'h02, 7552);
      close_out;
   end
   initial begin
      #1000000;
      error_cnt = error_cnt + 1;
      close_out;
   end
endmodule // ctxe_encoder_tb
